// ===== core/xbs_dev.sv
// processor end of the external local bus: strobes, wait, hold, lock, status
// assumes the far end keeps its own handshake; pin inputs are synchronised here
`timescale 1ns/10ps
`default_nettype none
`include "xbs_cfg.svh"
// What this block does
// RULE1 - 32-bit two-way data bus for both directions
// RULE2 - write_not_read high on write; read_not_write inverse
// RULE3 - read strobe only with valid address, select
// RULE4 - write strobe only with valid address, select
// RULE5 - wait stretches cycle on wait-enabled selects
// RULE6 - drive active machine number on two outputs
// RULE7 - far decode flags forbidden access by error
// RULE8 - master requests hold, uses bus after grant
// RULE9 - lock held across atomic sequence; arbiter honours
// RULE10 - transfer request starts current master's operation
// RULE11 - acknowledge when done; master finishes after it
// RULE12 - executive mode output, forced on handler entry
// RULE13 - trusted mode output means full rights
// RULE14 - multiplexed pins default to named function
// RULE15 - code_not_data high on fetch, low data
// RULE16 - grant hold acknowledge on hold request
// RULE17 - freeze strobe, address, select while waiting
// RULE18 - error aborts access uncommitted, recorded sticky
module xbs_dev
(
  input  wire logic             sys_clk_i,    // 40 MHz clock
  input  wire logic             rst_i,        // sync reset, high
  input  wire logic             clk_en_i,     // freezes all state when low
  xbs_if.dev                    bus,          // pins
  input  wire logic             req_i,        // core access request
  input  wire logic             req_write_i,  // access is a write
  input  wire logic             req_fetch_i,  // access is a fetch
  input  wire logic             req_lock_i,   // access belongs to locked run
  input  wire xbs_pkg::xbs_addr_t req_addr_i, // access address
  input  wire xbs_pkg::xbs_data_t req_wdata_i,// write data
  input  wire xbs_pkg::xbs_cs_t wait_en_i,    // per-select wait enable
  input  wire logic             pin_mux_i,    // 0 = named pin functions
  input  wire logic             exec_i,       // core executive mode
  input  wire logic             trap_entry_i, // handler entry pulse
  input  wire logic             trusted_i,    // core trusted mode
  input  wire logic [1:0]       machine_i,    // active machine number
  input  wire logic             err_clear_i,  // clears error flag
  output logic                  busy_o,       // access in progress
  output logic                  done_o,       // access finished pulse
  output xbs_pkg::xbs_data_t    rdata_o,      // read data
  output logic                  err_o,        // sticky error flag
  output logic                  held_o,       // bus given away
  output logic                  ext_req_o     // external transfer request seen
);
  import xbs_pkg::*;

  // decode the select from the address; used for pins and wait check
  function automatic xbs_cs_t cs_decode(input xbs_addr_t a);
    xbs_cs_t s;
    s = '1;
    s[a[`XBS_CS_SHIFT+`XBS_CS_IDX_W-1:`XBS_CS_SHIFT]] = 1'b0;
    return s;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers: first stage read only by the second
  logic [4:0] s1_q;  // first stage
  logic [4:0] s2_q;  // second stage
  logic [4:0] s1_d;
  logic [4:0] s2_d;
  xbs_data_t  ds1_q; // data first stage
  xbs_data_t  ds2_q; // data second stage
  xbs_data_t  ds1_d;
  xbs_data_t  ds2_d;
  always_comb
  begin
    s1_d  = s1_q;
    s2_d  = s2_q;
    ds1_d = ds1_q;
    ds2_d = ds2_q;
    if (rst_i)
    begin
      s1_d  = 5'h1f;
      s2_d  = 5'h1f;
      ds1_d = '0;
      ds2_d = '0;
    end
    else if (clk_en_i)
    begin
      s1_d  = {bus.transfer_request_n, bus.hold_request_n, bus.transfer_error_n,
               bus.wait_extend_n, 1'b1};
      s2_d  = s1_q;
      ds1_d = bus.data;
      ds2_d = ds1_q;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    s1_q  <= s1_d;
    s2_q  <= s2_d;
    ds1_q <= ds1_d;
    ds2_q <= ds2_d;
  end
  logic wait_act;  // synchronised wait asserted
  logic err_act;   // synchronised error asserted
  logic hold_act;  // synchronised hold request
  logic xrq_act;   // synchronised transfer request
  assign wait_act = ~s2_q[1];
  assign err_act  = ~s2_q[2];
  assign hold_act = ~s2_q[3] & ~pin_mux_i;  // [RULE14]
  assign xrq_act  = ~s2_q[4] & ~pin_mux_i;  // [RULE14]

  //////////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer
  xbs_state_e state_q, state_d;
  xbs_addr_t  addr_q, addr_d;
  xbs_cs_t    cs_q, cs_d;
  xbs_data_t  wdata_q, wdata_d, rdata_q, rdata_d;
  logic       wr_q, wr_d, fetch_q, fetch_d, lock_q, lock_d, oe_q, oe_d;
  logic       re_n_q, re_n_d, we_n_q, we_n_d, grant_n_q, grant_n_d;
  logic       ack_n_q, ack_n_d, done_q, done_d, err_q, err_d;
  logic       ext_q, ext_d, busy_q, busy_d;  // busy kept in a flop so the output is registered
  logic [1:0] cnt_q, cnt_d;   // strobe width counter
  logic       may_wait;       // selected chip has waiting on

  assign may_wait = |(~cs_q & wait_en_i);

  // next-state logic for the sequencer
  always_comb
  begin
    state_d = state_q; addr_d = addr_q; cs_d = cs_q; wdata_d = wdata_q;
    rdata_d = rdata_q; wr_d = wr_q; fetch_d = fetch_q; lock_d = lock_q;
    oe_d = oe_q; re_n_d = re_n_q; we_n_d = we_n_q; grant_n_d = grant_n_q;
    ack_n_d = ack_n_q; done_d = 1'b0; err_d = err_q; ext_d = xrq_act;
    cnt_d = cnt_q;
    if (err_clear_i)
      err_d = 1'b0;
    unique case (state_q)
      XBS_IDLE:
      begin
        ack_n_d = 1'b1;
        if (hold_act && !lock_q)  // never give the bus away mid-lock [RULE9]
        begin
          grant_n_d = 1'b0;       // [RULE8] [RULE16]
          state_d   = XBS_HELD;
        end
        else if (req_i)
        begin
          // address and select settle one cycle before any strobe [RULE3] [RULE4]
          addr_d  = req_addr_i;
          cs_d    = cs_decode(req_addr_i);
          wr_d    = req_write_i;  // [RULE2]
          fetch_d = req_fetch_i;  // [RULE15]
          lock_d  = req_lock_i;   // [RULE9]
          wdata_d = req_wdata_i;
          oe_d    = req_write_i;  // [RULE1]
          cnt_d   = `XBS_STROBE_CYC;
          state_d = XBS_STROBE;
        end
        else if (!req_lock_i)
          lock_d = 1'b0;          // lock ends once the core leaves the atomic run [RULE9]
      end
      XBS_STROBE:
      begin
        re_n_d = wr_q;            // [RULE3]
        we_n_d = ~wr_q;           // [RULE4]
        state_d = XBS_WAIT;
      end
      XBS_WAIT:
      begin
        if (err_act)
        begin
          // drop the strobe early so nothing is written or taken [RULE18]
          err_d   = 1'b1;
          re_n_d  = 1'b1;
          we_n_d  = 1'b1;
          ack_n_d = 1'b0;         // [RULE11]
          state_d = XBS_ACK;
        end
        else if (wait_act && may_wait)
          cnt_d = cnt_q;          // hold everything while stretched [RULE5] [RULE17]
        else if (cnt_q != 2'h0)
          cnt_d = cnt_q - 2'h1;
        else
        begin
          if (!wr_q)
            rdata_d = ds2_q;      // [RULE1]
          re_n_d  = 1'b1;
          we_n_d  = 1'b1;
          ack_n_d = 1'b0;         // [RULE11]
          state_d = XBS_ACK;
        end
      end
      XBS_ACK:
      begin
        oe_d    = 1'b0;
        cs_d    = '1;
        ack_n_d = 1'b1;
        done_d  = 1'b1;
        if (!req_lock_i)
          lock_d = 1'b0;
        state_d = XBS_IDLE;
      end
      XBS_HELD:
      begin
        // one acknowledge per new external request, else the master never finishes [RULE11]
        ack_n_d = ~(xrq_act & ~ext_q);  // [RULE10]
        if (!hold_act)
        begin
          grant_n_d = 1'b1;       // [RULE16]
          state_d   = XBS_IDLE;
        end
      end
      default: state_d = XBS_IDLE;
    endcase
    if (done_d && err_act && state_q == XBS_ACK)
      err_d = 1'b1;               // a new error wins over a clear
    busy_d = (state_d != XBS_IDLE) && (state_d != XBS_HELD);
  end

  // register stage; clock enable freezes everything
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= XBS_IDLE; addr_q <= '0; cs_q <= '1; wdata_q <= '0; rdata_q <= '0;
      wr_q <= 1'b0; fetch_q <= 1'b0; lock_q <= 1'b0; oe_q <= 1'b0;
      re_n_q <= 1'b1; we_n_q <= 1'b1; grant_n_q <= 1'b1; ack_n_q <= 1'b1;
      done_q <= 1'b0; err_q <= 1'b0; ext_q <= 1'b0; cnt_q <= 2'h0; busy_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_q <= state_d; addr_q <= addr_d; cs_q <= cs_d; wdata_q <= wdata_d;
      rdata_q <= rdata_d; wr_q <= wr_d; fetch_q <= fetch_d; lock_q <= lock_d;
      oe_q <= oe_d; re_n_q <= re_n_d; we_n_q <= we_n_d; grant_n_q <= grant_n_d;
      ack_n_q <= ack_n_d; done_q <= done_d; err_q <= err_d; ext_q <= ext_d;
      cnt_q <= cnt_d; busy_q <= busy_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status outputs registered straight from the core's mode inputs
  logic [3:0] mode_q, mode_d;
  always_comb
  begin
    mode_d = mode_q;
    if (rst_i)
      mode_d = 4'h1;              // executive, untrusted, machine 0
    else if (clk_en_i)
      mode_d = {machine_i, trusted_i, exec_i | trap_entry_i}; // [RULE12] [RULE13] [RULE6]
  end
  always_ff @(posedge sys_clk_i)
    mode_q <= mode_d;

  // pin drives
  assign bus.dev_data_o         = wdata_q;
  assign bus.dev_data_oe        = oe_q;            // [RULE1]
  assign bus.addr               = addr_q;
  assign bus.cs_n               = cs_q;
  assign bus.write_not_read     = wr_q;            // [RULE2]
  assign bus.read_not_write     = ~wr_q;           // [RULE2]
  assign bus.read_en_n          = re_n_q;
  assign bus.write_en_n         = we_n_q;
  assign bus.hold_grant_n       = grant_n_q;
  assign bus.bus_lock_n         = ~lock_q;         // [RULE9]
  assign bus.transfer_ack_n     = ack_n_q;
  assign bus.code_not_data      = fetch_q;         // [RULE15]
  assign bus.exec_user_mode     = mode_q[0];
  assign bus.trusted_mode       = mode_q[1];
  assign bus.machine_index_bit0 = mode_q[2];       // [RULE6]
  assign bus.machine_index_bit1 = mode_q[3];
  assign busy_o    = busy_q;
  assign done_o    = done_q;
  assign rdata_o   = rdata_q;
  assign err_o     = err_q;
  assign held_o    = ~grant_n_q;
  assign ext_req_o = ext_q;                        // [RULE10]
endmodule
`default_nettype wire

// ===== core/xbs_cfg.svh
// constants for the external local bus signalling block
// assumes inclusion by both bus ends and the carrier interface
`ifndef XBS_CFG_SVH
`define XBS_CFG_SVH
`define XBS_DW        32
`define XBS_AW        28
`define XBS_CSW       8
`define XBS_CS_SHIFT  22
`define XBS_CS_IDX_W  3
`define XBS_STROBE_CYC 2'h2
`define XBS_DATA_MSB  31
`endif

// ===== core/xbs_pkg.sv
// types shared by both ends of the external local bus
// assumes xbs_cfg.svh is on the include path
`include "xbs_cfg.svh"
package xbs_pkg;
  typedef logic [`XBS_DW-1:0]  xbs_data_t;
  typedef logic [`XBS_AW-1:0]  xbs_addr_t;
  typedef logic [`XBS_CSW-1:0] xbs_cs_t;
  typedef enum logic [2:0]
  {
    XBS_IDLE   = 3'b000,
    XBS_STROBE = 3'b001,
    XBS_WAIT   = 3'b010,
    XBS_ACK    = 3'b011,
    XBS_HELD   = 3'b100
  } xbs_state_e;
endpackage

// ===== core/xbs_if.sv
// carrier between the processor bus end and the far side (memory/master/decode)
// resolves the two-way data pins from the two drive enables
`timescale 1ns/10ps
`default_nettype none
`include "xbs_cfg.svh"
interface xbs_if;
  import xbs_pkg::*;
  xbs_data_t dev_data_o;      // data driven by the device
  logic      dev_data_oe;     // device drives data
  xbs_data_t far_data_o;      // data driven by the far side
  logic      far_data_oe;     // far side drives data
  xbs_data_t data;            // resolved data bus level
  xbs_addr_t addr;            // address
  xbs_cs_t   cs_n;            // chip selects, active low
  logic      write_not_read;  // high on write
  logic      read_not_write;  // inverse
  logic      read_en_n;       // read strobe
  logic      write_en_n;      // write strobe
  logic      wait_extend_n;   // wait from far side
  logic      transfer_error_n;// access violation from far side
  logic      hold_request_n;  // bus request from external master
  logic      hold_grant_n;    // grant to external master
  logic      bus_lock_n;      // atomic sequence
  logic      transfer_request_n; // start of external-master transfer
  logic      transfer_ack_n;  // transfer done
  logic      code_not_data;   // fetch vs data
  logic      exec_user_mode;  // executive when high
  logic      trusted_mode;    // trusted when high
  logic      machine_index_bit0; // active machine bit 0
  logic      machine_index_bit1; // active machine bit 1
  // the wire reads as all ones (pull-up) when nobody drives
  assign data = dev_data_oe ? dev_data_o : (far_data_oe ? far_data_o : '1);
  modport dev
  (
    output dev_data_o, dev_data_oe, addr, cs_n, write_not_read, read_not_write,
    output read_en_n, write_en_n, hold_grant_n, bus_lock_n, transfer_ack_n,
    output code_not_data, exec_user_mode, trusted_mode,
    output machine_index_bit0, machine_index_bit1,
    input  data, wait_extend_n, transfer_error_n, hold_request_n, transfer_request_n
  );
  modport far
  (
    output far_data_o, far_data_oe, wait_extend_n, transfer_error_n,
    output hold_request_n, transfer_request_n,
    input  data, addr, cs_n, write_not_read, read_not_write, read_en_n, write_en_n,
    input  hold_grant_n, bus_lock_n, transfer_ack_n, code_not_data,
    input  exec_user_mode, trusted_mode, machine_index_bit0, machine_index_bit1
  );
endinterface
`default_nettype wire

// ===== core/xbs_far.sv
// far side logic: external master, wait source and access decode
// assumes the processor end grants hold and acknowledges transfers
`timescale 1ns/10ps
`default_nettype none
`include "xbs_cfg.svh"
module xbs_far
(
  input  wire logic      sys_clk_i,   // 40 MHz clock
  input  wire logic      rst_i,       // sync reset, high
  input  wire logic      clk_en_i,    // freezes all state when low
  xbs_if.far             bus,         // pins
  input  wire logic      want_bus_i,  // user wants bus mastership
  input  wire logic      start_i,     // user starts a transfer
  input  wire logic      stretch_i,   // user asks to hold wait
  input  wire xbs_pkg::xbs_cs_t deny_cs_i, // selects forbidden to untrusted
  output logic           owner_o,     // bus granted to us
  output logic           xfer_done_o  // our transfer finished pulse
);
  import xbs_pkg::*;
  logic hreq_q, hreq_d, xrq_q, xrq_d, err_q, err_d, wait_q, wait_d;
  logic owner_q, owner_d, busy_q, busy_d, done_q, done_d;
  logic g1_q, g2_q, a1_q, a2_q;      // synchronisers for grant and ack

  // next values of far-side requests and decode
  always_comb
  begin
    hreq_d = want_bus_i | busy_q;     // keep holding during a transfer [RULE8]
    owner_d = ~g2_q;
    busy_d = busy_q;
    xrq_d = 1'b0;
    done_d = 1'b0;
    if (start_i && owner_q && !busy_q)  // only start once granted [RULE8] [RULE10]
    begin
      xrq_d  = 1'b1;
      busy_d = 1'b1;
    end
    else if (busy_q && !a2_q)           // finish only after ack [RULE11]
    begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end
    wait_d = stretch_i;                 // [RULE5]
    err_d  = ~bus.trusted_mode && ((~bus.cs_n & deny_cs_i) != '0); // [RULE7]
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      hreq_q <= 1'b0; xrq_q <= 1'b0; err_q <= 1'b0; wait_q <= 1'b0;
      owner_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0;
      g1_q <= 1'b1; g2_q <= 1'b1; a1_q <= 1'b1; a2_q <= 1'b1;
    end
    else if (clk_en_i)
    begin
      hreq_q <= hreq_d; xrq_q <= xrq_d; err_q <= err_d; wait_q <= wait_d;
      owner_q <= owner_d; busy_q <= busy_d; done_q <= done_d;
      g1_q <= bus.hold_grant_n; g2_q <= g1_q;
      a1_q <= bus.transfer_ack_n; a2_q <= a1_q;
    end
  end
  assign bus.far_data_o         = ~xbs_data_t'(bus.addr);  // read data: the inverted address
  assign bus.far_data_oe        = ~bus.read_en_n;          // answer only under the read strobe [RULE1]
  assign bus.hold_request_n     = ~hreq_q;
  assign bus.transfer_request_n = ~xrq_q;
  assign bus.transfer_error_n   = ~err_q;
  assign bus.wait_extend_n      = ~wait_q;
  assign owner_o     = owner_q;
  assign xfer_done_o = done_q;
endmodule
`default_nettype wire

// ===== dv/xbs_checker.sv
// concurrent checks on the pins between the processor end and the far side
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module xbs_checker
  import xbs_pkg::*;
(
  input wire logic      sys_clk_i,      // bus clock
  input wire logic      rst_i,          // sync reset, high
  input wire xbs_addr_t addr,           // address pins
  input wire xbs_cs_t   cs_n,           // chip selects
  input wire logic      dev_data_oe,    // device drives data
  input wire logic      write_not_read, // high on write
  input wire logic      read_not_write, // inverse pin
  input wire logic      read_en_n,      // read strobe
  input wire logic      write_en_n,     // write strobe
  input wire logic      hold_request_n, // master asks for bus
  input wire logic      hold_grant_n,   // bus given away
  input wire logic      bus_lock_n,     // atomic run
  input wire logic      transfer_ack_n  // transfer done
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // strobe phases; the ack step must land on the strobe's closing edge
  sequence s_strobe_on;
    !read_en_n || !write_en_n;
  endsequence
  sequence s_strobe_off;
    $rose(read_en_n) || $rose(write_en_n);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_rw_inverse: assert property (write_not_read == !read_not_write)
    else $error("direction pins not inverse");
  a_read_strobe_valid: assert property (!read_en_n |-> cs_n != '1 && !write_not_read && !dev_data_oe)
    else $error("read strobe without valid select");
  a_write_strobe_valid: assert property (!write_en_n |-> cs_n != '1 && write_not_read && dev_data_oe)
    else $error("write strobe without valid select");
  a_select_single: assert property (cs_n != '1 |-> $onehot(~cs_n))
    else $error("more than one select low");
  // a stretched cycle must not let the address slide under the strobe
  a_wait_freeze: assert property (s_strobe_on ##1 s_strobe_on |-> $stable(addr) && $stable(cs_n))
    else $error("address moved under strobe");
  a_strobe_min_len: assert property ($fell(read_en_n) || $fell(write_en_n) |=> s_strobe_on)
    else $error("strobe shorter than two cycles");
  a_ack_after_strobe: assert property ($fell(transfer_ack_n) && hold_grant_n |-> s_strobe_off)
    else $error("ack before access end");
  a_ack_one_cycle: assert property ($fell(transfer_ack_n) |=> transfer_ack_n)
    else $error("ack longer than one cycle");
  a_grant_quiet: assert property (!hold_grant_n |-> bus_lock_n && read_en_n && write_en_n)
    else $error("grant while locked or strobing");
  // synchroniser delay lets the request lead the grant by a few cycles
  a_grant_cause: assert property ($fell(hold_grant_n) |-> !$past(hold_request_n, 2)
    || !$past(hold_request_n, 3) || !$past(hold_request_n, 4))
    else $error("grant without hold request");
  a_grant_release: assert property (hold_request_n [*6] |-> hold_grant_n)
    else $error("grant kept without request");
endmodule
`default_nettype wire

// ===== dv/xbs_bench.sv
// self-checking bench: processor end and far side joined by the carrier
// assumes a 40 MHz clock; clk_en_i is dropped once to check the freeze
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module xbs_bench;
  import xbs_pkg::*;
  logic      sys_clk_i = 0;  // bus clock
  logic      rst_i = 1;      // reset
  logic      clk_en_i = 1;   // run; dropped once
  logic      req_i = 0, req_write_i = 0, req_fetch_i = 0, req_lock_i = 0;
  xbs_addr_t req_addr_i = '0; // access address
  xbs_data_t req_wdata_i = '0;// write data
  xbs_cs_t   wait_en_i = '0, deny_cs_i = '0;
  logic      pin_mux_i = 0, exec_i = 0, trap_entry_i = 0, trusted_i = 0, err_clear_i = 0;
  logic [1:0] machine_i = '0; // active machine
  logic      want_bus_i = 0, start_i = 0, stretch_i = 0;
  logic      busy_o, done_o, err_o, held_o, ext_req_o, owner_o, xfer_done_o;
  xbs_data_t rdata_o;        // captured read data
  int        comparisons = 0, mismatches = 0, lat = 0;
  xbs_data_t cap_data;       // last values seen under a strobe
  xbs_addr_t cap_addr;
  xbs_cs_t   cap_cs;
  logic      cap_wnr, cap_cnd, cap_busy;
  logic      seen_ext = 1'b0; // transfer request reached the core
  always #12.5 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  xbs_if bus ();
  xbs_dev i_xbs_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .bus(bus),
    .req_i(req_i), .req_write_i(req_write_i), .req_fetch_i(req_fetch_i), .req_lock_i(req_lock_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .wait_en_i(wait_en_i),
    .pin_mux_i(pin_mux_i), .exec_i(exec_i), .trap_entry_i(trap_entry_i), .trusted_i(trusted_i),
    .machine_i(machine_i), .err_clear_i(err_clear_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .err_o(err_o), .held_o(held_o), .ext_req_o(ext_req_o));
  xbs_far i_xbs_far (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .bus(bus),
    .want_bus_i(want_bus_i), .start_i(start_i), .stretch_i(stretch_i), .deny_cs_i(deny_cs_i),
    .owner_o(owner_o), .xfer_done_o(xfer_done_o));
  xbs_checker i_xbs_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr(bus.addr),
    .cs_n(bus.cs_n), .dev_data_oe(bus.dev_data_oe), .write_not_read(bus.write_not_read),
    .read_not_write(bus.read_not_write), .read_en_n(bus.read_en_n),
    .write_en_n(bus.write_en_n), .hold_request_n(bus.hold_request_n),
    .hold_grant_n(bus.hold_grant_n), .bus_lock_n(bus.bus_lock_n),
    .transfer_ack_n(bus.transfer_ack_n));
  ////////////////////////////////////////////////////////////////////////////
  // snapshot of the pins while a strobe is low, judged once the access ends
  always @(posedge sys_clk_i)
    if (!bus.read_en_n || !bus.write_en_n)
    begin
      cap_data <= bus.data;
      cap_addr <= bus.addr;
      cap_cs <= bus.cs_n;
      cap_wnr <= bus.write_not_read;
      cap_cnd <= bus.code_not_data;
      cap_busy <= busy_o;
    end
  // sticky note that the core reported an external transfer request
  always @(posedge sys_clk_i)
    if (ext_req_o)
      seen_ext <= 1'b1;
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return done_o;
      1: return owner_o;
      2: return xfer_done_o;
      default: return !owner_o;
    endcase
  endfunction
  // bounded wait on a done, grant or release flag; running out ends the run
  task automatic wait_sig(input int w, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    while (sel(w) !== 1'b1 && n < lim);
    if (sel(w) !== 1'b1)
    begin
      mismatches++;
      $display("[ERR] wait %0d exp 1 got 0", w);
      summarize();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // one core access; hold > 0 asks the far side to stretch for that many cycles
  task automatic access(input logic wr, fe, lk, input xbs_addr_t a, input xbs_data_t d,
                        input int hold, output int n);
    cyc(1);
    req_i = 1;
    req_write_i = wr;
    req_fetch_i = fe;
    req_lock_i = lk;
    req_addr_i = a;
    req_wdata_i = d;
    stretch_i = (hold != 0);
    fork
      begin
        cyc(hold);
        stretch_i = 0;
      end
    join_none
    wait_sig(0, 80, n);
    req_i = 0;
    `CHK("select", 1'b0, cap_cs[a[24:22]])
    `CHK("address", a, cap_addr)
    `CHK("direction", wr, cap_wnr)
    `CHK("code flag", fe, cap_cnd)
    `CHK("busy", 1'b1, cap_busy)
    if (wr)
      `CHK("write data", d, cap_data)
    else
      `CHK("read data", cap_data, rdata_o)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    `CHK("idle strobes", 2'b11, {bus.read_en_n, bus.write_en_n})
    `CHK("idle grant", 1'b1, bus.hold_grant_n)
    `CHK("idle mode", 2'b10, {bus.exec_user_mode, bus.trusted_mode})
    rst_i = 0;
    // every select, both directions, fetches among the reads, two idle cycles between accesses
    for (int i = 0; i < 8; i++)
    begin
      access(i[0], !i[0] && i[1], 0, xbs_addr_t'({i[2:0], 22'h0015a4}),
             32'ha5c3_0f00 ^ i, 0, lat);
      `CHK("latency", 6, lat)
    end
    // wait honoured only where the select enables it
    wait_en_i = 8'h02;
    access(0, 0, 0, 28'h0400040, '0, 12, lat);
    `CHK("stretched", 1'b1, lat >= 12)
    cyc(8);
    access(0, 0, 0, 28'h0800040, '0, 12, lat);
    `CHK("not stretched", 6, lat)
    cyc(8);
    // status pins follow the core one cycle later
    for (int m = 0; m < 4; m++)
    begin
      exec_i = m[0];
      trusted_i = m[1];
      machine_i = m[1:0];
      cyc(1);
      `CHK("machine", m[1:0], {bus.machine_index_bit1, bus.machine_index_bit0})
      `CHK("modes", m[1:0], {bus.trusted_mode, bus.exec_user_mode})
    end
    // with the clock enable low the mode pins must not follow the core
    clk_en_i = 0;
    exec_i = 0;
    cyc(3);
    `CHK("frozen mode", 1'b1, bus.exec_user_mode)
    clk_en_i = 1;
    exec_i = 0;
    cyc(1);
    trap_entry_i = 1;
    cyc(1);
    trap_entry_i = 0;
    `CHK("trap exec", 1'b1, bus.exec_user_mode)
    // untrusted access to a denied select aborts and is recorded
    trusted_i = 0;
    deny_cs_i = 8'h08;
    access(1, 0, 0, 28'h0c00010, 32'h1234_5678, 0, lat);
    `CHK("error flag", 1'b1, err_o)
    err_clear_i = 1;
    cyc(1);
    err_clear_i = 0;
    cyc(1);
    `CHK("error cleared", 1'b0, err_o)
    trusted_i = 1;
    cyc(2);
    access(1, 0, 0, 28'h0c00010, 32'h1234_5678, 0, lat);
    `CHK("trusted no error", 1'b0, err_o)
    // hold ignored while the pin is muxed away, then granted
    pin_mux_i = 1;
    want_bus_i = 1;
    cyc(10);
    `CHK("muxed grant", 1'b1, bus.hold_grant_n)
    pin_mux_i = 0;
    wait_sig(1, 20, lat);
    `CHK("grant", 2'b01, {bus.hold_grant_n, held_o})
    start_i = 1;
    cyc(1);
    start_i = 0;
    wait_sig(2, 40, lat);
    `CHK("transfer seen", 1'b1, seen_ext)
    want_bus_i = 0;
    wait_sig(3, 20, lat);
    `CHK("released", 1'b0, held_o)
    // a locked run keeps the bus until lock is dropped
    access(0, 0, 1, 28'h0400080, '0, 0, lat);
    want_bus_i = 1;
    cyc(10);
    `CHK("locked", 2'b10, {bus.hold_grant_n, bus.bus_lock_n})
    req_lock_i = 0;
    wait_sig(1, 20, lat);
    `CHK("unlocked", 1'b1, bus.bus_lock_n)
    want_bus_i = 0;
    wait_sig(3, 20, lat);
    summarize();
  end
endmodule
`default_nettype wire
